// *** pkg/csl_pkg.sv ***
// package: constants for the cascadable serial shift link
package csl_pkg;
	localparam int CSL_SHIFT_BITS    = 224;
	localparam int CSL_CHANNELS      = 12;
	localparam int CSL_SYNC_STAGES   = 2;
	// forwarded clock leads the data out step by this many sys_clk cycles
	localparam int CSL_CLK_FWD_DELAY = 1;
	localparam logic CSL_DATA_RST    = 1'h0;
endpackage

// *** pkg/csl_sync_if.sv ***
// interface: synchronised link levels and edge strobe between the sampler and the core
`timescale 1ns/1ps
`default_nettype none
interface csl_sync_if;
	logic clk_lvl;
	logic data_lvl;
	logic rise;
	logic cur_gnd;
	modport src (output clk_lvl, output data_lvl, output rise, output cur_gnd);
	modport dst (input clk_lvl, input data_lvl, input rise, input cur_gnd);
endinterface
`default_nettype wire

// *** hw/csl_sampler.sv ***
// module: two-flop synchronisers and rising-edge detector for the link pins
`timescale 1ns/1ps
`default_nettype none
module csl_sampler
	import csl_pkg::*;
(
	input  wire logic   sys_clk_in,
	input  wire logic   srst_in,
	input  wire logic   shift_clock_in,
	input  wire logic   serial_data_in,
	input  wire logic   current_set_gnd_in,
	csl_sync_if.src     sync
);
	logic [2:0] meta_r, meta_nxt;
	logic [2:0] stab_r, stab_nxt;
	logic       clk_d_r, clk_d_nxt;

	always_comb begin
		meta_nxt  = {current_set_gnd_in, serial_data_in, shift_clock_in};
		stab_nxt  = meta_r;
		clk_d_nxt = stab_r[0];
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			meta_r  <= 3'h0;
			stab_r  <= 3'h0;
			clk_d_r <= 1'h0;
		end else begin
			meta_r  <= meta_nxt;
			stab_r  <= stab_nxt;
			clk_d_r <= clk_d_nxt;
		end
	end

	// edge seen on the second stage only; data sampled in the same cycle is its value
	assign sync.clk_lvl  = stab_r[0];
	assign sync.data_lvl = stab_r[1];
	assign sync.cur_gnd  = stab_r[2];
	assign sync.rise     = stab_r[0] & ~clk_d_r;
endmodule
`default_nettype wire

// *** hw/csl_link.sv ***
// module: 224-bit cascadable serial shift register with clock forwarding
`timescale 1ns/1ps
`default_nettype none
module csl_link
	import csl_pkg::*;
#(
	parameter int SHIFT_BITS = CSL_SHIFT_BITS,
	parameter int CHANNELS   = CSL_CHANNELS
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  srst_in,
	input  wire logic                  shift_clock_in,
	input  wire logic                  serial_data_in,
	input  wire logic                  current_set_gnd_in,
	input  wire logic [CHANNELS-1:0]   channel_on_in,
	output var  logic                  serial_data_out,
	output var  logic                  shift_clock_out,
	output var  logic [CHANNELS-1:0]   channel_drive_out,
	output var  logic [SHIFT_BITS-1:0] shift_reg_out
);
	csl_sync_if sync ();

	csl_sampler u_sampler (
		.sys_clk_in         (sys_clk_in),
		.srst_in            (srst_in),
		.shift_clock_in     (shift_clock_in),
		.serial_data_in     (serial_data_in),
		.current_set_gnd_in (current_set_gnd_in),
		.sync               (sync)
	);

	//----------------------------------------
	// shift step
	//----------------------------------------
	// shift one cycle after the edge: forwarded clock rises while data out
	// still holds the leaving bit, so a chained device takes that bit
	logic step_r, step_nxt;
	logic dat_r, dat_nxt;

	always_comb begin
		step_nxt = sync.rise;
		dat_nxt  = sync.data_lvl;
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			step_r <= 1'h0;
			dat_r  <= CSL_DATA_RST;
		end else begin
			step_r <= step_nxt;
			dat_r  <= dat_nxt;
		end
	end

	//----------------------------------------
	// shift path
	//----------------------------------------
	logic [SHIFT_BITS-1:0] sreg_r, sreg_nxt;
	logic                  sdo_r, sdo_nxt;

	always_comb begin
		sreg_nxt = sreg_r;
		if (step_r) begin
			sreg_nxt = {sreg_r[SHIFT_BITS-2:0], dat_r};
		end
		// taken from the next value so data out moves in the same step
		sdo_nxt = sreg_nxt[SHIFT_BITS-1];
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sreg_r <= '0;
			sdo_r  <= CSL_DATA_RST;
		end else begin
			sreg_r <= sreg_nxt;
			sdo_r  <= sdo_nxt;
		end
	end

	//----------------------------------------
	// clock forwarding
	//----------------------------------------
	logic sck_r, sck_nxt;

	always_comb begin
		// follows the synchronised pin, one cycle ahead of the shift
		sck_nxt = sync.clk_lvl;
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sck_r <= 1'h0;
		end else begin
			sck_r <= sck_nxt;
		end
	end

	//----------------------------------------
	// channel gating
	//----------------------------------------
	// grounded terminal wins over any on request
	var  logic [CHANNELS-1:0] drv_r;
	wire logic [CHANNELS-1:0] drv_nxt;

	for (genvar g = 0; g < CHANNELS; g++) begin : g_gate
		assign drv_nxt[g] = sync.cur_gnd ? 1'h0 : channel_on_in[g];
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			drv_r <= '0;
		end else begin
			drv_r <= drv_nxt;
		end
	end

	//----------------------------------------
	// outputs
	//----------------------------------------
	assign serial_data_out   = sdo_r;
	assign shift_clock_out   = sck_r;
	assign channel_drive_out = drv_r;
	assign shift_reg_out     = sreg_r;

	//----------------------------------------
	// checks
	//----------------------------------------
	property p_capture;
		@(posedge sys_clk_in) disable iff (srst_in)
		step_r |=> (sreg_r[0] == $past(dat_r));
	endproperty
	a_capture: assert property (p_capture) else $error("bit zero missed data");

	property p_shift;
		@(posedge sys_clk_in) disable iff (srst_in)
		step_r |=> (sreg_r[SHIFT_BITS-1:1] == $past(sreg_r[SHIFT_BITS-2:0]));
	endproperty
	a_shift: assert property (p_shift) else $error("register did not shift");

	property p_hold;
		@(posedge sys_clk_in) disable iff (srst_in)
		!step_r |=> $stable(sreg_r);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved without edge");

	property p_msb;
		@(posedge sys_clk_in) disable iff (srst_in)
		serial_data_out == sreg_r[SHIFT_BITS-1];
	endproperty
	a_msb: assert property (p_msb) else $error("data out not top bit");

	property p_sdo_step;
		@(posedge sys_clk_in) disable iff (srst_in)
		!$stable(serial_data_out) |-> $past(step_r);
	endproperty
	a_sdo_step: assert property (p_sdo_step) else $error("data out moved off step");

	property p_fwd;
		@(posedge sys_clk_in) disable iff (srst_in)
		sync.rise |=> shift_clock_out;
	endproperty
	a_fwd: assert property (p_fwd) else $error("clock not forwarded");

	property p_fwd_low;
		@(posedge sys_clk_in) disable iff (srst_in)
		$fell(sync.clk_lvl) |=> !shift_clock_out;
	endproperty
	a_fwd_low: assert property (p_fwd_low) else $error("forwarded clock stuck");

	property p_off;
		@(posedge sys_clk_in) disable iff (srst_in)
		sync.cur_gnd |=> (channel_drive_out == '0);
	endproperty
	a_off: assert property (p_off) else $error("outputs on while grounded");

	property p_pass;
		@(posedge sys_clk_in) disable iff (srst_in)
		!sync.cur_gnd |=> (channel_drive_out == $past(channel_on_in));
	endproperty
	a_pass: assert property (p_pass) else $error("on request not passed");

	property p_step;
		@(posedge sys_clk_in) disable iff (srst_in)
		sync.rise |=> step_r;
	endproperty
	a_step: assert property (p_step) else $error("shift step not taken");

	property p_rise_once;
		@(posedge sys_clk_in) disable iff (srst_in)
		sync.rise |=> !sync.rise;
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("edge seen twice");

	property p_follow;
		@(posedge sys_clk_in) disable iff (srst_in)
		shift_clock_out == $past(sync.clk_lvl);
	endproperty
	a_follow: assert property (p_follow) else $error("forwarded clock off pin level");

	// chained device must see the clock rise before data out moves
	property p_lead;
		@(posedge sys_clk_in) disable iff (srst_in)
		$rose(shift_clock_out) |-> (step_r && $stable(serial_data_out));
	endproperty
	a_lead: assert property (p_lead) else $error("clock did not lead data out");

	property p_sdo_idle;
		@(posedge sys_clk_in) disable iff (srst_in)
		!step_r |=> $stable(serial_data_out);
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("data out moved idle");

	property p_reg_top;
		@(posedge sys_clk_in) disable iff (srst_in)
		shift_reg_out[SHIFT_BITS-1] == serial_data_out;
	endproperty
	a_reg_top: assert property (p_reg_top) else $error("register top differs");
endmodule
`default_nettype wire

// *** bench/csl_host_model.sv ***
// partner: host clocking one bit into the link every 8 system cycles
`timescale 1ns/1ps
`default_nettype none
module csl_host_model (
	input  wire logic sys_clk_in,
	input  wire logic run_in,
	input  wire logic bit_in,
	output var  logic sck_out,
	output var  logic sdi_out
);
	logic [2:0] cnt_r;
	initial begin
		cnt_r = 3'h0;
		sck_out = 1'h0;
		sdi_out = 1'h0;
	end
	always @(posedge sys_clk_in) begin
		cnt_r <= run_in ? cnt_r + 3'h1 : 3'h0;
		if (!run_in) begin
			sck_out <= 1'h0;
			// idle data toggles so a stale level is never mistaken for data
			sdi_out <= ~sdi_out;
		end else if (cnt_r == 3'h3) begin
			sck_out <= 1'h0;
			sdi_out <= bit_in;
		end else if (cnt_r == 3'h7) begin
			sck_out <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// *** bench/tb_cascadable_serial_shift_link.sv ***
// testbench: shift order, clock alignment and output gating of csl_link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t mismatch", $time); end end
module tb_cascadable_serial_shift_link;
	import csl_pkg::*;
	logic                      clk = 1'h0, rst = 1'h1, run = 1'h0, bitv = 1'h0, gnd = 1'h0;
	logic [11:0]               on = 12'h000, drv;
	logic                      sck, sdi, sdo, sco;
	logic [CSL_SHIFT_BITS-1:0] sreg, exp_r;
	int                        err_total = 0, cmp_count = 0;
	always #12.5 clk = ~clk;
	csl_host_model i_host (.sys_clk_in(clk), .run_in(run), .bit_in(bitv), .sck_out(sck),
		.sdi_out(sdi));
	csl_link i_dut (.sys_clk_in(clk), .srst_in(rst), .shift_clock_in(sck),
		.serial_data_in(sdi), .current_set_gnd_in(gnd), .channel_on_in(on),
		.serial_data_out(sdo), .shift_clock_out(sco), .channel_drive_out(drv),
		.shift_reg_out(sreg));
	task conclude;
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task reset_check;
		repeat (5) @(posedge clk);
		`CHK({sdo, sreg}, '0)
		rst <= 1'h0;
	endtask
	// runs past 224 bits so the first bits are seen leaving at the top
	task shift_check;
		int i;
		int w;
		exp_r = '0;
		run <= 1'h1;
		for (i = 0; i < CSL_SHIFT_BITS + 8; i++) begin
			w = 0;
			do begin
				@(posedge clk);
				w++;
			end while (sck !== 1'h1 && w < 20);
			if (w >= 20) begin
				err_total++;
				conclude();
			end
			bitv <= ^(8'(i + 1) & 8'h2D);
			@(posedge clk);
			`CHK({sco, sreg}, {1'h0, exp_r})
			repeat (2) @(posedge clk);
			// forwarded clock is up while data out still holds the leaving bit
			`CHK({sco, sdo, sreg}, {1'h1, exp_r[CSL_SHIFT_BITS-1], exp_r})
			exp_r = {exp_r[CSL_SHIFT_BITS-2:0], ^(8'(i) & 8'h2D)};
			@(posedge clk);
			`CHK({sco, sreg}, {1'h1, exp_r})
			`CHK(sdo, exp_r[CSL_SHIFT_BITS-1])
		end
		run <= 1'h0;
	endtask
	task gate_check;
		on <= 12'hFFF;
		gnd <= 1'h1;
		repeat (6) @(posedge clk);
		`CHK(drv, 12'h000)
		on <= 12'hA5C;
		gnd <= 1'h0;
		repeat (6) @(posedge clk);
		`CHK(drv, 12'hA5C)
	endtask
	initial begin
		reset_check();
		shift_check();
		gate_check();
		conclude();
	end
endmodule
`default_nettype wire
